/* core/upc_usb_power_ctrl.sv */
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module upc_usb_power_ctrl (
    input wire logic clk_sys, // System clock, 10 MHz
    input wire logic rst_n, // Power-on reset, active low
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic [31:0] hrdata, // AHB read data
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response
    input wire logic bus_reset_sig, // Bus reset signalling present
    input wire logic suspend_sig, // Suspend signalling seen, pulse
    input wire logic resume_sig, // Resume signalling seen, pulse
    input wire logic sof_evt, // Start of frame, pulse
    input wire logic req_done, // Device request completed, pulse
    input wire logic [3:0] in_ep_evt, // IN endpoint events, pulses
    input wire logic in_packet_ready, // Iso IN packet loaded
    input wire logic in_token, // IN token for iso endpoint, pulse
    output logic [6:0] usb_addr, // Address in use
    output logic usb_enable, // Function enabled
    output logic suspended, // Suspend mode flag
    output logic resume_drive, // Drive resume on bus
    output logic fifo_flush, // Flush endpoint FIFOs, pulse
    output logic csr_clear, // Clear endpoint control regs, pulse
    output logic [3:0] ep_index, // Endpoint index
    output logic send_packet, // Send loaded packet, pulse
    output logic send_zlp, // Send zero-length packet, pulse
    output logic usb_irq // Interrupt request
);
    logic soft_rst_reg;
    logic frst_n;
    logic [6:0] addr_new_reg;
    logic [6:0] addr_act_reg;
    logic addr_pend_reg;
    logic iso_reg;
    logic inh_reg;
    logic suspend_detect_enable_reg;
    logic suspend_mode_flag_reg;
    logic resdrv_reg;
    logic rsu_seen_reg;
    logic [3:0] cm_flag_reg;
    logic [3:0] cm_flag_next;
    logic [3:0] in_flag_reg;
    logic [3:0] in_flag_next;
    logic [3:0] cm_en_reg;
    logic [3:0] in_en_reg;
    logic [3:0] epsel_reg;
    logic cpuen_reg;
    logic brst_d_reg;
    logic sof_seen_reg;
    logic flush_reg;
    logic snd_reg;
    logic zlp_reg;
    logic wr_pend_reg;
    logic [5:0] wr_idx_reg;
    logic [31:0] hrdata_reg;

    // Bus request decode
    wire take = hsel & hready & (htrans == upc_pkg::HTRANS_NONSEQ);
    wire [5:0] a_idx = haddr[7:2];
    wire rd = take & ~hwrite;
    wire mapped = (haddr[31:8] == 24'h000000);
    wire [7:0] wd = hwdata[7:0];
    wire wr_addr = wr_pend_reg & (wr_idx_reg == upc_pkg::IDX_FUNCTION_ADDRESS_REG);
    wire wr_pwr = wr_pend_reg & (wr_idx_reg == upc_pkg::IDX_PWR);
    wire wr_inen = wr_pend_reg & (wr_idx_reg == upc_pkg::IDX_INEN);
    wire wr_cmen = wr_pend_reg & (wr_idx_reg == upc_pkg::IDX_CMEN);
    wire wr_sel = wr_pend_reg & (wr_idx_reg == upc_pkg::IDX_EPSEL);
    wire wr_cpu = wr_pend_reg & (wr_idx_reg == upc_pkg::IDX_CPUEN);
    wire rd_cm = rd & mapped & (a_idx == upc_pkg::IDX_CMFLG);
    wire rd_in = rd & mapped & (a_idx == upc_pkg::IDX_INFLG);

    // Traffic gated by inhibit
    wire live = ~inh_reg;
    wire brst_rise = live & bus_reset_sig & ~brst_d_reg;
    wire sus_det = live & suspend_sig & suspend_detect_enable_reg & ~suspend_mode_flag_reg;
    wire rsu_det = live & resume_sig & suspend_mode_flag_reg;
    wire res_end = wr_pwr & ~wd[upc_pkg::P_RES] & resdrv_reg;
    wire res_go = wr_pwr & wd[upc_pkg::P_RES] & suspend_mode_flag_reg;

    // Writing one to reset-detect fires a one-cycle function reset
    wire soft_go = wr_pwr & wd[upc_pkg::P_RST];
    assign frst_n = rst_n & ~soft_rst_reg;

    // Soft reset clears itself the next cycle and is reset only by power-on reset, so it cannot hang
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            soft_rst_reg <= 1'b0;
        end else begin
            soft_rst_reg <= soft_go & ~soft_rst_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge frst_n) begin
        if (!frst_n) begin
            brst_d_reg <= 1'b0;
        end else begin
            brst_d_reg <= live & bus_reset_sig;
        end
    end

    // Function address
    always_ff @(posedge clk_sys or negedge frst_n) begin
        if (!frst_n) begin
            addr_new_reg <= upc_pkg::RST_ADDR;
        end else if (brst_rise) begin
            addr_new_reg <= upc_pkg::RST_ADDR;
        end else if (wr_addr) begin
            addr_new_reg <= wd[6:0];
        end
    end

    always_ff @(posedge clk_sys or negedge frst_n) begin
        if (!frst_n) begin
            addr_act_reg <= upc_pkg::RST_ADDR;
        end else if (brst_rise) begin
            addr_act_reg <= upc_pkg::RST_ADDR;
        end else if (addr_pend_reg & req_done & live) begin
            addr_act_reg <= addr_new_reg;
        end
    end

    // A write in the same cycle as completion stays pending
    always_ff @(posedge clk_sys or negedge frst_n) begin
        if (!frst_n) begin
            addr_pend_reg <= 1'b0;
        end else if (brst_rise) begin
            addr_pend_reg <= 1'b0;
        end else if (wr_addr) begin
            addr_pend_reg <= 1'b1;
        end else if (req_done & live) begin
            addr_pend_reg <= 1'b0;
        end
    end

    // Power register fields
    always_ff @(posedge clk_sys or negedge frst_n) begin
        if (!frst_n) begin
            iso_reg <= 1'b0;
            suspend_detect_enable_reg <= 1'b0;
        end else if (wr_pwr) begin
            iso_reg <= wd[upc_pkg::P_ISO];
            suspend_detect_enable_reg <= wd[upc_pkg::P_SUSPEND_DETECT_ENABLE];
        end
    end

    always_ff @(posedge clk_sys or negedge frst_n) begin
        if (!frst_n) begin
            inh_reg <= upc_pkg::RST_INH;
        end else if (wr_pwr & ~wd[upc_pkg::P_INH]) begin
            inh_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge frst_n) begin
        if (!frst_n) begin
            resdrv_reg <= 1'b0;
        end else if (brst_rise) begin
            resdrv_reg <= 1'b0;
        end else if (res_go) begin
            resdrv_reg <= 1'b1;
        end else if (res_end) begin
            resdrv_reg <= 1'b0;
        end
    end

    // Suspend mode flag; bus reset wins, then entry wins over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge frst_n) begin
        if (!frst_n) begin
            suspend_mode_flag_reg <= 1'b0;
        end else if (brst_rise) begin
            suspend_mode_flag_reg <= 1'b0;
        end else if (sus_det) begin
            suspend_mode_flag_reg <= 1'b1;
        end else if (res_end | (rd_cm & rsu_seen_reg)) begin
            suspend_mode_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge frst_n) begin
        if (!frst_n) begin
            rsu_seen_reg <= 1'b0;
        end else if (rsu_det) begin
            rsu_seen_reg <= 1'b1;
        end else if (rd_cm | brst_rise | ~suspend_mode_flag_reg) begin
            rsu_seen_reg <= 1'b0;
        end
    end

    // Common flags: hardware sets win over read-clear
    always_comb begin
        cm_flag_next = cm_flag_reg;
        if (rd_cm | brst_rise) begin
            cm_flag_next = upc_pkg::RST_FLAGS;
        end
        if (sus_det) begin
            cm_flag_next[upc_pkg::C_SUS] = 1'b1;
        end
        if (rsu_det | res_end) begin
            cm_flag_next[upc_pkg::C_RSU] = 1'b1;
        end
        if (brst_rise) begin
            cm_flag_next[upc_pkg::C_RST] = 1'b1;
        end
        if (live & sof_evt) begin
            cm_flag_next[upc_pkg::C_SOF] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge frst_n) begin
        if (!frst_n) begin
            cm_flag_reg <= upc_pkg::RST_FLAGS;
        end else begin
            cm_flag_reg <= cm_flag_next;
        end
    end

    always_comb begin
        in_flag_next = in_flag_reg;
        if (rd_in | brst_rise) begin
            in_flag_next = upc_pkg::RST_FLAGS;
        end
        if (live) begin
            in_flag_next = in_flag_next | in_ep_evt;
        end
    end

    always_ff @(posedge clk_sys or negedge frst_n) begin
        if (!frst_n) begin
            in_flag_reg <= upc_pkg::RST_FLAGS;
        end else begin
            in_flag_reg <= in_flag_next;
        end
    end

    // Per-source enables
    always_ff @(posedge clk_sys or negedge frst_n) begin
        if (!frst_n) begin
            cm_en_reg <= upc_pkg::RST_CMEN;
        end else if (brst_rise) begin
            cm_en_reg <= upc_pkg::BUSRST_CMEN;
        end else if (wr_cmen) begin
            cm_en_reg <= wd[3:0];
        end
    end

    always_ff @(posedge clk_sys or negedge frst_n) begin
        if (!frst_n) begin
            in_en_reg <= upc_pkg::RST_INEN;
        end else if (brst_rise) begin
            in_en_reg <= upc_pkg::BUSRST_INEN;
        end else if (wr_inen) begin
            in_en_reg <= wd[3:0];
        end
    end

    always_ff @(posedge clk_sys or negedge frst_n) begin
        if (!frst_n) begin
            epsel_reg <= upc_pkg::RST_EPSEL;
        end else if (brst_rise) begin
            epsel_reg <= upc_pkg::RST_EPSEL;
        end else if (wr_sel) begin
            epsel_reg <= wd[3:0];
        end
    end

    // Processor-level enable lives outside the function reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cpuen_reg <= upc_pkg::RST_CPUEN;
        end else if (wr_cpu) begin
            cpuen_reg <= wd[0];
        end
    end

    always_ff @(posedge clk_sys or negedge frst_n) begin
        if (!frst_n) begin
            flush_reg <= 1'b0;
        end else begin
            flush_reg <= brst_rise;
        end
    end

    // Iso update: hold the packet until a frame start has been seen
    wire iso_tok = live & in_token & in_packet_ready;
    always_ff @(posedge clk_sys or negedge frst_n) begin
        if (!frst_n) begin
            sof_seen_reg <= 1'b0;
        end else if (live & sof_evt) begin
            sof_seen_reg <= 1'b1;
        end else if (iso_tok | ~in_packet_ready) begin
            sof_seen_reg <= 1'b0;
        end
    end

    wire iso_ok = ~iso_reg | sof_seen_reg;
    always_ff @(posedge clk_sys or negedge frst_n) begin
        if (!frst_n) begin
            snd_reg <= 1'b0;
            zlp_reg <= 1'b0;
        end else begin
            snd_reg <= iso_tok & iso_ok;
            zlp_reg <= iso_tok & ~iso_ok;
        end
    end

    // Bus slave: writes land in the data phase, reads sample at address
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 6'h3f;
        end else begin
            wr_pend_reg <= take & hwrite & mapped;
            wr_idx_reg <= a_idx;
        end
    end

    wire [7:0] pwr_rd = {iso_reg, 2'b00, inh_reg, bus_reset_sig,
                         resdrv_reg, suspend_mode_flag_reg, suspend_detect_enable_reg};
    wire [7:0] rd_mux =
        (a_idx == upc_pkg::IDX_FUNCTION_ADDRESS_REG) ? {addr_pend_reg, addr_new_reg} :
        (a_idx == upc_pkg::IDX_PWR) ? pwr_rd :
        (a_idx == upc_pkg::IDX_INFLG) ? {4'h0, in_flag_reg} :
        (a_idx == upc_pkg::IDX_CMFLG) ? {4'h0, cm_flag_reg} :
        (a_idx == upc_pkg::IDX_INEN) ? {4'h0, in_en_reg} :
        (a_idx == upc_pkg::IDX_CMEN) ? {4'h0, cm_en_reg} :
        (a_idx == upc_pkg::IDX_EPSEL) ? {4'h0, epsel_reg} :
        (a_idx == upc_pkg::IDX_CPUEN) ? {7'h00, cpuen_reg} : 8'h00;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_reg <= 32'h00000000;
        end else if (rd) begin
            hrdata_reg <= {24'h000000, mapped ? rd_mux : 8'h00};
        end
    end

    wire any_irq = |(cm_flag_reg & cm_en_reg) | |(in_flag_reg & in_en_reg);

    assign hrdata = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign usb_addr = addr_act_reg;
    assign usb_enable = live;
    assign suspended = suspend_mode_flag_reg;
    assign resume_drive = resdrv_reg;
    assign fifo_flush = flush_reg;
    assign csr_clear = flush_reg;
    assign ep_index = epsel_reg;
    assign send_packet = snd_reg;
    assign send_zlp = zlp_reg;
    assign usb_irq = any_irq & cpuen_reg;
endmodule

/* core/upc_pkg.sv */
package upc_pkg;
    // Register indexes; byte address is four times the index
    localparam logic [5:0] IDX_FUNCTION_ADDRESS_REG = 6'h00;
    localparam logic [5:0] IDX_PWR = 6'h01;
    localparam logic [5:0] IDX_INFLG = 6'h02;
    localparam logic [5:0] IDX_CMFLG = 6'h06;
    localparam logic [5:0] IDX_INEN = 6'h07;
    localparam logic [5:0] IDX_CMEN = 6'h0b;
    localparam logic [5:0] IDX_EPSEL = 6'h0e;
    localparam logic [5:0] IDX_CPUEN = 6'h10;
    // Power register field positions
    localparam int P_ISO = 7;
    localparam int P_INH = 4;
    localparam int P_RST = 3;
    localparam int P_RES = 2;
    localparam int P_SUSPEND_MODE_FLAG = 1;
    localparam int P_SUSPEND_DETECT_ENABLE = 0;
    // Common flag positions
    localparam int C_SOF = 3;
    localparam int C_RST = 2;
    localparam int C_RSU = 1;
    localparam int C_SUS = 0;
    // Function address field
    localparam int A_PEND = 7;
    // Values after reset
    localparam logic [6:0] RST_ADDR = 7'h00;
    localparam logic RST_INH = 1'b1;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic [3:0] RST_INEN = 4'hf;
    localparam logic [3:0] RST_CMEN = 4'h6;
    localparam logic [3:0] BUSRST_INEN = 4'hf;
    localparam logic [3:0] BUSRST_CMEN = 4'he;
    localparam logic [3:0] RST_EPSEL = 4'h0;
    localparam logic RST_CPUEN = 1'b0;
    // Remote wakeup length expected from firmware, in microseconds
    localparam int WAKE_MIN_US = 10000;
    localparam int WAKE_MAX_US = 15000;
    localparam int CLK_MHZ = 10;
    localparam int WAKE_MIN_CYC = WAKE_MIN_US * CLK_MHZ;
    localparam int WAKE_MAX_CYC = WAKE_MAX_US * CLK_MHZ;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage

/* testbench/upc_usb_power_ctrl_chk.sv */
`timescale 1ns/1ps
module upc_usb_power_ctrl_chk (
    input wire logic clk_sys, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic [31:0] hrdata, // Read data
    input wire logic hreadyout, // Slave ready
    input wire logic hresp, // Response
    input wire logic bus_reset_sig, // Bus reset level
    input wire logic suspend_sig, // Suspend seen
    input wire logic req_done, // Request done
    input wire logic in_packet_ready, // Packet loaded
    input wire logic in_token, // IN token
    input wire logic [6:0] usb_addr, // Address in use
    input wire logic usb_enable, // Function enabled
    input wire logic suspended, // Suspend flag
    input wire logic resume_drive, // Resume drive
    input wire logic fifo_flush, // Flush pulse
    input wire logic csr_clear, // Clear pulse
    input wire logic [3:0] ep_index, // Endpoint index
    input wire logic send_packet, // Send packet
    input wire logic send_zlp // Send empty packet
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence s_busrst;
        usb_enable && $rose(bus_reset_sig);
    endsequence
    sequence s_cleared;
        fifo_flush && csr_clear && usb_addr == 7'h00 && ep_index == 4'h0;
    endsequence
    property p_busrst_clear;
        s_busrst |=> s_cleared;
    endproperty
    a_busrst_clear: assert property (p_busrst_clear)
        else $error("bus reset left state");
    property p_busrst_susp;
        s_busrst |=> !suspended;
    endproperty
    a_busrst_susp: assert property (p_busrst_susp)
        else $error("bus reset kept suspend");
    property p_flush_pulse;
        fifo_flush |-> csr_clear ##1 !fifo_flush;
    endproperty
    a_flush_pulse: assert property (p_flush_pulse)
        else $error("flush pulse shape");
    property p_addr_src;
        $changed(usb_addr) && usb_addr != 7'h00 |-> $past(req_done);
    endproperty
    a_addr_src: assert property (p_addr_src)
        else $error("address changed early");
    property p_susp_src;
        $rose(suspended) |-> $past(suspend_sig && usb_enable);
    endproperty
    a_susp_src: assert property (p_susp_src)
        else $error("suspend without cause");
    property p_iso_src;
        send_packet || send_zlp |-> $past(in_token && usb_enable);
    endproperty
    a_iso_src: assert property (p_iso_src)
        else $error("send without token");
    property p_iso_one;
        usb_enable && in_token && in_packet_ready |=> send_packet != send_zlp;
    endproperty
    a_iso_one: assert property (p_iso_one)
        else $error("token answer wrong");
    property p_wake_src;
        $rose(resume_drive) |-> $past(suspended);
    endproperty
    a_wake_src: assert property (p_wake_src)
        else $error("wakeup while awake");
    property p_wake_end;
        $fell(resume_drive) |-> !suspended;
    endproperty
    a_wake_end: assert property (p_wake_end)
        else $error("suspend kept after wakeup");
    property p_bus_ok;
        hreadyout && !hresp && hrdata[31:8] == 24'h000000;
    endproperty
    a_bus_ok: assert property (p_bus_ok)
        else $error("bus answer wrong");
endmodule

bind upc_usb_power_ctrl upc_usb_power_ctrl_chk i_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .bus_reset_sig(bus_reset_sig),
    .suspend_sig(suspend_sig), .req_done(req_done),
    .in_packet_ready(in_packet_ready), .in_token(in_token),
    .usb_addr(usb_addr), .usb_enable(usb_enable), .suspended(suspended),
    .resume_drive(resume_drive), .fifo_flush(fifo_flush),
    .csr_clear(csr_clear), .ep_index(ep_index),
    .send_packet(send_packet), .send_zlp(send_zlp)
);

/* testbench/upc_host_model.sv */
`timescale 1ns/1ps
module upc_host_model (
    input wire logic clk_sys, // Clock
    output logic bus_reset_sig, // Bus reset level
    output logic suspend_sig, // Suspend pulse
    output logic resume_sig, // Resume pulse
    output logic sof_evt, // Frame start pulse
    output logic req_done, // Request done pulse
    output logic [3:0] in_ep_evt, // Endpoint pulses
    output logic in_packet_ready, // Packet loaded
    output logic in_token // IN token pulse
);
    initial begin
        {bus_reset_sig, in_packet_ready} = 2'b00;
        {in_token, req_done, sof_evt, resume_sig, suspend_sig} = 5'h00;
        in_ep_evt = 4'h0;
    end
    // Order: token, request done, frame start, resume, suspend
    task automatic pulse(input logic [4:0] m, input logic [3:0] ep);
        @(posedge clk_sys);
        {in_token, req_done, sof_evt, resume_sig, suspend_sig} <= m;
        in_ep_evt <= ep;
        @(posedge clk_sys);
        {in_token, req_done, sof_evt, resume_sig, suspend_sig} <= 5'h00;
        in_ep_evt <= 4'h0;
    endtask
    // Reset signalling is a level held for as long as the host wants
    task automatic brst(input logic v);
        @(posedge clk_sys);
        bus_reset_sig <= v;
    endtask
    task automatic ready(input logic v);
        @(posedge clk_sys);
        in_packet_ready <= v;
    endtask
endmodule

/* testbench/upc_usb_power_ctrl_bench.sv */
`timescale 1ns/1ps
module upc_usb_power_ctrl_bench;
    logic clk_sys, rst_n, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic bus_reset_sig, suspend_sig, resume_sig, sof_evt, req_done;
    logic in_packet_ready, in_token, usb_enable, suspended, resume_drive;
    logic fifo_flush, csr_clear, send_packet, send_zlp, usb_irq;
    logic [3:0] in_ep_evt, ep_index;
    logic [6:0] usb_addr;
    int miscompares = 0;
    int num_checks = 0;
    upc_usb_power_ctrl i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .bus_reset_sig(bus_reset_sig),
        .suspend_sig(suspend_sig), .resume_sig(resume_sig),
        .sof_evt(sof_evt), .req_done(req_done), .in_ep_evt(in_ep_evt),
        .in_packet_ready(in_packet_ready), .in_token(in_token),
        .usb_addr(usb_addr), .usb_enable(usb_enable),
        .suspended(suspended), .resume_drive(resume_drive),
        .fifo_flush(fifo_flush), .csr_clear(csr_clear),
        .ep_index(ep_index), .send_packet(send_packet),
        .send_zlp(send_zlp), .usb_irq(usb_irq)
    );
    upc_host_model i_host (
        .clk_sys(clk_sys), .bus_reset_sig(bus_reset_sig),
        .suspend_sig(suspend_sig), .resume_sig(resume_sig),
        .sof_evt(sof_evt), .req_done(req_done), .in_ep_evt(in_ep_evt),
        .in_packet_ready(in_packet_ready), .in_token(in_token)
    );
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic chk(input string n, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic addr_ph(input logic [5:0] idx, input logic w);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= upc_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= 3'b010;
        haddr <= {24'h000000, idx, 2'b00};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        addr_ph(idx, 1'b1);
        hwdata <= {24'h000000, d};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
    endtask
    task automatic rdc(input string n, input logic [5:0] idx,
                       input logic [7:0] e);
        addr_ph(idx, 1'b0);
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        chk(n, hrdata, {24'h000000, e});
    endtask
    task automatic st;
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic done(input string n);
        $display("test %s done", n);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        // Remote wakeup alone holds the bus for about ten milliseconds
        repeat (upc_pkg::WAKE_MIN_CYC + 5000) @(posedge clk_sys);
        miscompares++;
        end_sim;
    end
    initial begin
        rst_n = 1'b0;
        {hsel, hwrite, htrans} = 4'h0;
        hsize = 3'b010;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdc("pwr", upc_pkg::IDX_PWR, 8'h10);
        rdc("function_address_reg", upc_pkg::IDX_FUNCTION_ADDRESS_REG, 8'h00);
        rdc("unmapped", 6'h3f, 8'h00);
        i_host.pulse(5'h01, 4'hf);
        st;
        rdc("inflg", upc_pkg::IDX_INFLG, 8'h00);
        chk("en", usb_enable, 0);
        wr(upc_pkg::IDX_PWR, 8'h18);
        wr(upc_pkg::IDX_CPUEN, 8'h01);
        chk("en", usb_enable, 0);
        wr(upc_pkg::IDX_PWR, 8'h00);
        wr(upc_pkg::IDX_PWR, 8'h10);
        rdc("pwr", upc_pkg::IDX_PWR, 8'h00);
        chk("en", usb_enable, 1);
        done("enable");
        i_host.pulse(5'h00, 4'hf);
        st;
        chk("irq", usb_irq, 1);
        wr(upc_pkg::IDX_INFLG, 8'hff);
        rdc("inflg", upc_pkg::IDX_INFLG, 8'h0f);
        rdc("inflg", upc_pkg::IDX_INFLG, 8'h00);
        chk("irq", usb_irq, 0);
        wr(upc_pkg::IDX_INEN, 8'h00);
        i_host.pulse(5'h00, 4'h2);
        st;
        chk("irq", usb_irq, 0);
        rdc("inflg", upc_pkg::IDX_INFLG, 8'h02);
        done("flags");
        wr(upc_pkg::IDX_FUNCTION_ADDRESS_REG, 8'h25);
        rdc("function_address_reg", upc_pkg::IDX_FUNCTION_ADDRESS_REG, 8'ha5);
        chk("addr", usb_addr, 0);
        i_host.pulse(5'h08, 4'h0);
        st;
        rdc("function_address_reg", upc_pkg::IDX_FUNCTION_ADDRESS_REG, 8'h25);
        chk("addr", usb_addr, 32'h25);
        done("address");
        i_host.pulse(5'h01, 4'h0);
        st;
        chk("susp", suspended, 0);
        rdc("cmflg", upc_pkg::IDX_CMFLG, 8'h00);
        wr(upc_pkg::IDX_PWR, 8'h01);
        i_host.pulse(5'h01, 4'h0);
        st;
        chk("susp", suspended, 1);
        rdc("pwr", upc_pkg::IDX_PWR, 8'h03);
        rdc("cmflg", upc_pkg::IDX_CMFLG, 8'h01);
        wr(upc_pkg::IDX_PWR, 8'h05);
        st;
        chk("wake", resume_drive, 1);
        repeat (upc_pkg::WAKE_MIN_CYC) @(posedge clk_sys);
        chk("wake", resume_drive, 1);
        wr(upc_pkg::IDX_PWR, 8'h01);
        st;
        chk("wake", resume_drive, 0);
        chk("susp", suspended, 0);
        rdc("cmflg", upc_pkg::IDX_CMFLG, 8'h02);
        i_host.pulse(5'h01, 4'h0);
        i_host.pulse(5'h02, 4'h0);
        st;
        chk("irq", usb_irq, 1);
        rdc("cmflg", upc_pkg::IDX_CMFLG, 8'h03);
        chk("susp", suspended, 0);
        done("suspend");
        wr(upc_pkg::IDX_EPSEL, 8'h03);
        i_host.pulse(5'h01, 4'h0);
        chk("index", ep_index, 3);
        i_host.brst(1'b1);
        rdc("pwr", upc_pkg::IDX_PWR, 8'h09);
        i_host.brst(1'b0);
        st;
        chk("index", ep_index, 0);
        rdc("function_address_reg", upc_pkg::IDX_FUNCTION_ADDRESS_REG, 8'h00);
        rdc("inen", upc_pkg::IDX_INEN, 8'h0f);
        rdc("cmen", upc_pkg::IDX_CMEN, 8'h0e);
        rdc("cmflg", upc_pkg::IDX_CMFLG, 8'h04);
        rdc("pwr", upc_pkg::IDX_PWR, 8'h01);
        done("bus reset");
        i_host.ready(1'b1);
        i_host.pulse(5'h10, 4'h0);
        @(negedge clk_sys);
        chk("pkt", send_packet, 1);
        wr(upc_pkg::IDX_PWR, 8'h81);
        i_host.pulse(5'h10, 4'h0);
        @(negedge clk_sys);
        chk("zlp", send_zlp, 1);
        i_host.pulse(5'h04, 4'h0);
        i_host.pulse(5'h10, 4'h0);
        @(negedge clk_sys);
        chk("pkt", send_packet, 1);
        done("iso");
        wr(upc_pkg::IDX_FUNCTION_ADDRESS_REG, 8'h11);
        i_host.pulse(5'h08, 4'h0);
        wr(upc_pkg::IDX_PWR, 8'h08);
        st;
        rdc("pwr", upc_pkg::IDX_PWR, 8'h10);
        rdc("function_address_reg", upc_pkg::IDX_FUNCTION_ADDRESS_REG, 8'h00);
        rdc("cmen", upc_pkg::IDX_CMEN, 8'h06);
        chk("en", usb_enable, 0);
        done("function reset");
        end_sim;
    end
endmodule
